// >>> swsf_regs.svh
// Geometry, code levels and timing constants of the window formatter.
// Contract
// - The window size can be set from 4 by 2 up to 640 columns by 480 rows.
// - The window can start anywhere as long as it stays inside 664 by 492.
// - Window size or position never changes frame rate or pixel rate.
// - Line valid is high only for positions inside the programmed window.
// - After reset the window is 640 by 480 at full resolution.
// - A quarter mode gives 320 by 240 images by sub-sampling the array.
// - Quarter mode drops pixels both along the line and between lines.
// - Luma and RGB black sits at code 16 and peak white is held at 240.
// - Chroma zero is code 128 and chroma stays between 16 and 240.
// - Raw RGB samples always fall in the range 16 to 240.
// - Codes 0 and 255 never appear as pixel data.
// - The 10-bit path runs in step with the pixel rate, at most 12 MHz; only master mode holds this, the slave link clock is not limited.
// - One channel carries luma or green, the other alternates chroma.
// - Rows alternate blue-green and green-red and output follows that.
// - Data, line valid and frame sync all move with the pixel clock.
// - Data is valid on the falling edge unless the edge select is set.
`ifndef SWSF_REGS_SVH
`define SWSF_REGS_SVH

// Full array and window limits.
`define SWSF_ARRAY_COLS 10'h298
`define SWSF_ARRAY_ROWS 9'h1EC
`define SWSF_WIN_MAX_COLS 10'h280
`define SWSF_WIN_MAX_ROWS 9'h1E0
`define SWSF_WIN_MIN_COLS 10'h004
`define SWSF_WIN_MIN_ROWS 9'h002

// Reset window placement, centred in the array.
`define SWSF_DEF_COL_START 10'h00C
`define SWSF_DEF_ROW_START 9'h006

// Output code levels.
`define SWSF_CODE_BLACK 8'h10
`define SWSF_CODE_PEAK 8'hF0
`define SWSF_CODE_CHROMA_ZERO 8'h80

// Rows at the top of each frame that carry frame sync.
`define SWSF_FS_ROWS 9'h003

// Clock rates in hertz and the pixel clock divider.
`define SWSF_CLK_HZ 25000000
`define SWSF_MAX_PIX_HZ 12000000
`define SWSF_MIN_DIV ((`SWSF_CLK_HZ + `SWSF_MAX_PIX_HZ - 1) / `SWSF_MAX_PIX_HZ)
`define SWSF_DEF_DIV 4

// Sample buffer shape.
`define SWSF_SAMPLE_BITS 10
`define SWSF_FIFO_DEPTH 16

`endif

// >>> swsf_pkg.sv
// Types shared by the window formatter modules.
package swsf_pkg;

  // Output byte format.
  typedef enum logic [1:0] {
    fmt_ycbcr,
    fmt_rgb422,
    fmt_raw
  } swsf_fmt_t;

  // Complete state of the formatter.
  typedef struct packed {
    logic link_meta;
    logic link_sync;
    logic pix_prev;
    logic [7:0] div_cnt;
    logic gen_clk;
    logic [9:0] col;
    logic [8:0] row;
    logic [9:0] cs;
    logic [8:0] rs;
    logic [9:0] cw;
    logic [8:0] rh;
    logic quarter;
    swsf_fmt_t fmt;
    logic edge_sel;
    logic master;
    logic [7:0] data;
    logic lv;
    logic fs;
    logic pclk;
    logic chan_chroma;
    logic underrun;
    logic frame_done;
  } swsf_state_t;

endpackage : swsf_pkg

// >>> swsf_fifo.sv
// Sample buffer between the converter channels and the formatter.
module swsf_fifo #(
  parameter int WIDTH = 20,
  parameter int DEPTH = 16
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic reset_n,
  // Filling side.
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  // Draining side.
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  import swsf_pkg::*;

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = AW + 1;

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [CW-1:0] count;
    logic ready;
  } swsf_fifo_state_t;

  swsf_fifo_state_t st_reg;
  swsf_fifo_state_t st_next;
  logic push;
  logic pop;

  // Ready is registered from the next count so the filler sees full at once.
  always_comb begin
    push = in_valid && st_reg.ready;
    pop = out_ready && (st_reg.count != '0);
    st_next = st_reg;
    if (push) begin
      st_next.mem[st_reg.wr] = in_data;
      st_next.wr = (st_reg.wr == AW'(DEPTH - 1)) ? '0 : st_reg.wr + 1'b1;
    end
    if (pop) begin
      st_next.rd = (st_reg.rd == AW'(DEPTH - 1)) ? '0 : st_reg.rd + 1'b1;
    end
    st_next.count = st_reg.count + CW'(push) - CW'(pop);
    st_next.ready = (st_next.count != CW'(DEPTH));
  end

  // State register.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      st_reg <= '0;
      st_reg.ready <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign in_ready = st_reg.ready;
  assign out_valid = (st_reg.count != '0);
  assign out_data = st_reg.mem[st_reg.rd];

endmodule : swsf_fifo

// >>> swsf_formatter.sv
// Output window, quarter sub-sampling and code formatting of the sensor.
`include "swsf_regs.svh"

module swsf_formatter #(
  parameter int PIX_DIV = `SWSF_DEF_DIV,
  parameter int FIFO_DEPTH = `SWSF_FIFO_DEPTH
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic reset_n,
  // Pixel clock from an external timing master.
  input wire logic link_pclk,
  // Timing and format settings.
  input wire logic master_mode,
  input wire logic data_edge_select,
  input wire logic quarter_res,
  input wire swsf_pkg::swsf_fmt_t out_format,
  // Window settings.
  input wire logic [9:0] win_col_start,
  input wire logic [8:0] win_row_start,
  input wire logic [9:0] win_cols,
  input wire logic [8:0] win_rows,
  // Converter samples.
  input wire logic [9:0] luma_sample,
  input wire logic [9:0] chroma_sample,
  input wire logic sample_valid,
  output logic sample_ready,
  // Video port.
  output logic [7:0] pix_data,
  output logic line_valid,
  output logic frame_sync,
  output logic pclk_out,
  output logic underrun
);
  import swsf_pkg::*;

  localparam int SB = `SWSF_SAMPLE_BITS;
  localparam int FW = 2 * SB;
  localparam int DIV_EFF = (PIX_DIV < `SWSF_MIN_DIV) ? `SWSF_MIN_DIV : PIX_DIV;
  localparam logic [7:0] HALF_M1 = 8'((DIV_EFF + 1) / 2 - 1);
  localparam logic [9:0] LAST_COL = `SWSF_ARRAY_COLS - 10'h001;
  localparam logic [8:0] LAST_ROW = `SWSF_ARRAY_ROWS - 9'h001;

  swsf_state_t st_reg;
  swsf_state_t st_next;

  // Buffer handshake and decode terms.
  logic fifo_valid;
  logic [FW-1:0] fifo_data;
  logic fifo_pop;
  logic pix_level;
  logic tick;
  logic frame_end;
  logic [9:0] rel_col;
  logic [8:0] rel_row;
  logic in_win;
  logic keep;
  logic emit;
  logic pick_chroma;
  logic [9:0] w_in;
  logic [8:0] h_in;
  logic [9:0] cs_max;
  logic [8:0] rs_max;

  // Truncates a 10-bit sample and holds it inside the legal code range.
  function automatic logic [7:0] clip_code(input logic [9:0] s);
    logic [7:0] c;
    c = s[9:2];
    if (c < `SWSF_CODE_BLACK) begin
      c = `SWSF_CODE_BLACK;
    end else if (c > `SWSF_CODE_PEAK) begin
      c = `SWSF_CODE_PEAK;
    end
    return c;
  endfunction : clip_code

  // The buffer absorbs converter jitter; the pixel schedule drains it.
  swsf_fifo #(
    .WIDTH(FW),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clock(clock),
    .reset_n(reset_n),
    .in_valid(sample_valid),
    .in_data({luma_sample, chroma_sample}),
    .in_ready(sample_ready),
    .out_valid(fifo_valid),
    .out_data(fifo_data),
    .out_ready(fifo_pop)
  );

  // Pixel clock source and launch edge selection.
  always_comb begin
    pix_level = st_reg.master ? st_reg.gen_clk : st_reg.link_sync;
    // Data moves on the edge opposite to the one the receiver samples.
    if (st_reg.edge_sel) begin
      tick = !pix_level && st_reg.pix_prev;
    end else begin
      tick = pix_level && !st_reg.pix_prev;
    end
  end

  // Window decode against the latched geometry.
  always_comb begin
    rel_col = st_reg.col - st_reg.cs;
    rel_row = st_reg.row - st_reg.rs;
    in_win = (st_reg.col >= st_reg.cs) && (rel_col < st_reg.cw) &&
             (st_reg.row >= st_reg.rs) && (rel_row < st_reg.rh);
    // Pairs of columns and pairs of rows are kept so Bayer order survives.
    keep = !st_reg.quarter || (!rel_col[1] && !rel_row[1]);
    emit = in_win && keep;
    if (st_reg.fmt == fmt_raw) begin
      pick_chroma = (st_reg.row[0] == st_reg.col[0]);
    end else begin
      pick_chroma = !st_reg.col[0];
    end
    fifo_pop = tick && emit;
    frame_end = tick && (st_reg.col == LAST_COL) && (st_reg.row == LAST_ROW);
  end

  // Clamping of requested geometry to the legal window.
  always_comb begin
    w_in = win_cols;
    if (win_cols < `SWSF_WIN_MIN_COLS) begin
      w_in = `SWSF_WIN_MIN_COLS;
    end else if (win_cols > `SWSF_WIN_MAX_COLS) begin
      w_in = `SWSF_WIN_MAX_COLS;
    end
    h_in = win_rows;
    if (win_rows < `SWSF_WIN_MIN_ROWS) begin
      h_in = `SWSF_WIN_MIN_ROWS;
    end else if (win_rows > `SWSF_WIN_MAX_ROWS) begin
      h_in = `SWSF_WIN_MAX_ROWS;
    end
    // Start is pulled back rather than the size cut, keeping the size asked.
    cs_max = `SWSF_ARRAY_COLS - w_in;
    rs_max = `SWSF_ARRAY_ROWS - h_in;
  end

  // Next state of the whole formatter.
  always_comb begin
    st_next = st_reg;
    // The link clock passes two flip-flops before anything looks at it.
    st_next.link_meta = link_pclk;
    st_next.link_sync = st_reg.link_meta;
    st_next.pix_prev = pix_level;
    st_next.pclk = pix_level;
    // Own pixel clock for master mode, never faster than the converter.
    if (st_reg.div_cnt == HALF_M1) begin
      st_next.div_cnt = 8'h00;
      st_next.gen_clk = !st_reg.gen_clk;
    end else begin
      st_next.div_cnt = st_reg.div_cnt + 8'h01;
    end
    if (tick) begin
      // The raster walks the whole array whatever the window is.
      if (st_reg.col == LAST_COL) begin
        st_next.col = 10'h000;
        st_next.row = (st_reg.row == LAST_ROW) ? 9'h000 : st_reg.row + 9'h001;
      end else begin
        st_next.col = st_reg.col + 10'h001;
      end
      st_next.lv = emit;
      st_next.fs = (st_reg.row < `SWSF_FS_ROWS);
      st_next.chan_chroma = pick_chroma;
      if (!emit) begin
        st_next.data = `SWSF_CODE_BLACK;
      end else if (!fifo_valid) begin
        // A starved buffer shows black instead of stalling the raster.
        st_next.data = `SWSF_CODE_BLACK;
        st_next.underrun = 1'b1;
      end else if (pick_chroma) begin
        st_next.data = clip_code(fifo_data[SB-1:0]);
      end else begin
        st_next.data = clip_code(fifo_data[FW-1:SB]);
      end
    end
    // Geometry and timing choices swap only between frames.
    if (frame_end) begin
      st_next.cw = w_in;
      st_next.rh = h_in;
      st_next.cs = (win_col_start > cs_max) ? cs_max : win_col_start;
      st_next.rs = (win_row_start > rs_max) ? rs_max : win_row_start;
      st_next.quarter = quarter_res;
      st_next.fmt = out_format;
      st_next.edge_sel = data_edge_select;
      st_next.master = master_mode;
      st_next.frame_done = 1'b1;
      // A starved last pixel must not be lost to the clear, so set wins.
      st_next.underrun = emit && !fifo_valid;
    end
  end

  // State register with the reset geometry.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      st_reg <= '0;
      st_reg.cw <= `SWSF_WIN_MAX_COLS;
      st_reg.rh <= `SWSF_WIN_MAX_ROWS;
      st_reg.cs <= `SWSF_DEF_COL_START;
      st_reg.rs <= `SWSF_DEF_ROW_START;
      st_reg.master <= 1'b1;
      st_reg.data <= `SWSF_CODE_BLACK;
    end else begin
      st_reg <= st_next;
    end
  end

  // Video port outputs come straight from the state register.
  assign pix_data = st_reg.data;
  assign line_valid = st_reg.lv;
  assign frame_sync = st_reg.fs;
  assign pclk_out = st_reg.pclk;
  assign underrun = st_reg.underrun;

  // Helper count of pixel ticks within one frame.
  logic [18:0] frame_ticks;
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      frame_ticks <= 19'h00000;
    end else if (frame_end) begin
      frame_ticks <= 19'h00000;
    end else if (tick) begin
      frame_ticks <= frame_ticks + 19'h00001;
    end
  end

  localparam logic [18:0] FRAME_TICKS_M1 =
    19'(int'(`SWSF_ARRAY_COLS) * int'(`SWSF_ARRAY_ROWS) - 1);

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!reset_n);

  chk_win_size: assert property (
    st_reg.cw >= `SWSF_WIN_MIN_COLS && st_reg.cw <= `SWSF_WIN_MAX_COLS &&
    st_reg.rh >= `SWSF_WIN_MIN_ROWS && st_reg.rh <= `SWSF_WIN_MAX_ROWS)
    else $error("window size outside legal range");

  chk_win_inside: assert property (
    ({1'b0, st_reg.cs} + {1'b0, st_reg.cw}) <= {1'b0, `SWSF_ARRAY_COLS} &&
    ({1'b0, st_reg.rs} + {1'b0, st_reg.rh}) <= {1'b0, `SWSF_ARRAY_ROWS})
    else $error("window leaves the array");

  chk_frame_length: assert property (
    frame_end |-> frame_ticks == FRAME_TICKS_M1)
    else $error("frame length depends on the window");

  chk_lv_window: assert property (
    tick && !in_win |=> !line_valid)
    else $error("line valid outside the window");

  chk_reset_window: assert property (
    !st_reg.frame_done |-> st_reg.cw == `SWSF_WIN_MAX_COLS &&
      st_reg.rh == `SWSF_WIN_MAX_ROWS && !st_reg.quarter)
    else $error("reset geometry is not full window");

  chk_quarter_skip: assert property (
    tick && st_reg.quarter && in_win && (rel_col[1] || rel_row[1])
    |=> !line_valid)
    else $error("quarter mode kept a dropped pixel");

  chk_quarter_keep: assert property (
    tick && st_reg.quarter && in_win && !rel_col[1] && !rel_row[1]
    |=> line_valid)
    else $error("quarter mode dropped a kept pixel");

  chk_luma_range: assert property (
    line_valid && !st_reg.chan_chroma |->
      pix_data >= `SWSF_CODE_BLACK && pix_data <= `SWSF_CODE_PEAK)
    else $error("luma code out of range");

  chk_chroma_zero: assert property (
    fifo_pop && fifo_valid && pick_chroma &&
    fifo_data[SB-1:2] == `SWSF_CODE_CHROMA_ZERO
    |=> pix_data == `SWSF_CODE_CHROMA_ZERO)
    else $error("chroma zero not at its code");

  chk_raw_range: assert property (
    line_valid && st_reg.fmt == fmt_raw |->
      pix_data >= `SWSF_CODE_BLACK && pix_data <= `SWSF_CODE_PEAK)
    else $error("raw code out of range");

  chk_sync_codes: assert property (
    pix_data != 8'h00 && pix_data != 8'hFF)
    else $error("reserved sync code on the data port");

  chk_pix_rate: assert property (
    tick |=> !tick ##1 !tick)
    else $error("pixel rate above converter limit");

  chk_ycbcr_order: assert property (
    tick && emit && st_reg.fmt != fmt_raw |=>
      st_reg.chan_chroma == !$past(st_reg.col[0]))
    else $error("chroma channel not alternating with luma");

  chk_bayer_order: assert property (
    tick && emit && st_reg.fmt == fmt_raw && st_reg.row[0] && !st_reg.col[0]
    |=> !st_reg.chan_chroma)
    else $error("green-red row does not start with green");

  chk_sync_launch: assert property (
    $changed(line_valid) || $changed(frame_sync) |-> $past(tick))
    else $error("strobe moved off the pixel clock");

  chk_launch_edge: assert property (
    $changed(pix_data) |-> $past(tick) && pclk_out == !st_reg.edge_sel)
    else $error("data moved on the sampling edge");

  chk_cfg_frame: assert property (
    $changed(st_reg.cw) || $changed(st_reg.cs) || $changed(st_reg.rh) ||
    $changed(st_reg.rs) || $changed(st_reg.quarter) |-> $past(frame_end))
    else $error("geometry changed inside a frame");

  chk_underrun_set: assert property (
    tick && emit && !fifo_valid |=>
      underrun && pix_data == `SWSF_CODE_BLACK)
    else $error("starved pixel did not show black with underrun");

  chk_blank_black: assert property (
    tick && !emit |=> pix_data == `SWSF_CODE_BLACK && !line_valid)
    else $error("blanked position not at black");

  chk_chroma_range: assert property (
    line_valid && st_reg.chan_chroma |->
      pix_data >= `SWSF_CODE_BLACK && pix_data <= `SWSF_CODE_PEAK)
    else $error("chroma code out of range");

  chk_fs_rows: assert property (
    tick |=> frame_sync == ($past(st_reg.row) < `SWSF_FS_ROWS))
    else $error("frame sync outside its rows");

  chk_strobe_hold: assert property (
    !tick |=> $stable(line_valid) && $stable(frame_sync) &&
      $stable(pix_data))
    else $error("video port moved between pixel ticks");

  chk_raster_step: assert property (
    tick && st_reg.col != LAST_COL |=>
      st_reg.col == $past(st_reg.col) + 10'h001)
    else $error("raster column skipped");

endmodule : swsf_formatter

// >>> swsf_capture.sv
// Behavioural capture logic that receives the formatter's video port.
module swsf_capture (
  // Video port.
  input wire logic pclk,
  input wire logic edge_sel,
  input wire logic line_valid,
  input wire logic [7:0] pix_data,
  // Capture results.
  output logic [15:0] line_len,
  output logic [15:0] line_cnt,
  output logic [15:0] reserved_cnt
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] run_len;
  logic lv_seen;
  logic [7:0] bytes [$];

  // Start with empty counts so the first line is measured from zero.
  initial begin
    run_len = 16'h0000;
    line_len = 16'h0000;
    line_cnt = 16'h0000;
    reserved_cnt = 16'h0000;
    lv_seen = 1'b0;
  end

  // Sample only on the advertised edge, as a real receiver must.
  always @(pclk) begin
    if (pclk === edge_sel) begin
      if (line_valid === 1'b1) begin
        run_len = run_len + 16'h0001;
        bytes.push_back(pix_data);
        // Sync flag codes in the pixel stream would break a receiver.
        if (pix_data === 8'h00 || pix_data === 8'hFF) begin
          reserved_cnt = reserved_cnt + 16'h0001;
        end
      end else if (lv_seen) begin
        line_len = run_len;
        line_cnt = line_cnt + 16'h0001;
        run_len = 16'h0000;
      end
      lv_seen = (line_valid === 1'b1);
    end
  end
endmodule : swsf_capture

// >>> swsf_formatter_test.sv
// Self-checking bench for the window formatter over the opening rows of its first frame.
module swsf_formatter_test;
  timeunit 1ns;
  timeprecision 1ps;
  import swsf_pkg::*;
  localparam int PIX_DIV = 4;
  logic clock, reset_n, link_pclk, master_mode, data_edge_select;
  logic quarter_res, sample_valid, sample_ready, pclk_seen;
  swsf_fmt_t out_format;
  logic [9:0] win_col_start, win_cols, luma_sample, chroma_sample;
  logic [8:0] win_row_start, win_rows;
  logic line_valid, frame_sync, pclk_out, underrun;
  logic [7:0] pix_data;
  logic [15:0] line_len, line_cnt, reserved_cnt;
  int mismatches = 0;
  int samples_checked = 0;

  swsf_formatter #(.PIX_DIV(PIX_DIV), .FIFO_DEPTH(16)) i_swsf_formatter (
    .clock(clock), .reset_n(reset_n), .link_pclk(link_pclk),
    .master_mode(master_mode), .data_edge_select(data_edge_select),
    .quarter_res(quarter_res), .out_format(out_format),
    .win_col_start(win_col_start), .win_row_start(win_row_start),
    .win_cols(win_cols), .win_rows(win_rows),
    .luma_sample(luma_sample), .chroma_sample(chroma_sample),
    .sample_valid(sample_valid), .sample_ready(sample_ready),
    .pix_data(pix_data), .line_valid(line_valid),
    .frame_sync(frame_sync), .pclk_out(pclk_out), .underrun(underrun)
  );

  swsf_capture i_swsf_capture (
    .pclk(pclk_out), .edge_sel(data_edge_select),
    .line_valid(line_valid), .pix_data(pix_data),
    .line_len(line_len), .line_cnt(line_cnt), .reserved_cnt(reserved_cnt)
  );

  // System clock and an unrelated link clock.
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  initial begin
    link_pclk = 1'b0;
    forever #160 link_pclk = ~link_pclk;
  end

  // Remember the pixel clock level of the previous falling edge.
  always @(negedge clock) begin
    pclk_seen <= pclk_out;
  end

  function automatic logic rose_now();
    return pclk_out === 1'b1 && pclk_seen === 1'b0;
  endfunction : rose_now

  task automatic chk(input string what, input logic [15:0] exp, got);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_sim

  task automatic give_up(input string what);
    mismatches++;
    $display("mismatch %s expected event seen timeout", what);
    end_sim();
  endtask : give_up

  // Outputs while reset is held.
  task automatic test_reset;
    chk("reset outputs", {4'h0, 8'h10, 4'h0},
        {4'h0, pix_data, line_valid, frame_sync, pclk_out, underrun});
    $display("test reset done");
  endtask : test_reset

  // Frame sync spans three array rows at a fixed pixel period.
  task automatic test_sync_rate;
    int rises;
    int cycles;
    rises = 0;
    cycles = 0;
    for (int i = 0; i < 20 && frame_sync !== 1'b1; i++) begin
      @(negedge clock);
    end
    if (frame_sync !== 1'b1) begin
      give_up("frame_sync start");
    end
    while (frame_sync === 1'b1 && cycles < 9000) begin
      cycles++;
      if (rose_now()) begin
        rises++;
      end
      @(negedge clock);
    end
    chk("sync ticks", 16'h07C8, 16'(rises));
    chk("sync cycles", 16'(16'h07C8 * PIX_DIV), 16'(cycles));
    $display("test sync and rate done");
  endtask : test_sync_rate

  // Before the window opens nothing is popped, so the buffer refuses.
  task automatic test_fifo_full;
    sample_valid = 1'b1;
    repeat (20) @(negedge clock);
    chk("ready when full", 16'h0000, {15'h0000, sample_ready});
    $display("test fifo full done");
  endtask : test_fifo_full

  // Settings changed mid-frame must not alter the current frame.
  task automatic test_geometry_hold;
    int gap;
    gap = 0;
    quarter_res = 1'b1;
    win_cols = 10'h004;
    win_rows = 9'h002;
    win_col_start = 10'h000;
    win_row_start = 9'h000;
    out_format = fmt_raw;
    master_mode = 1'b0;
    for (int i = 0; i < 20000 && line_cnt !== 16'h0001; i++) begin
      @(negedge clock);
    end
    if (line_cnt !== 16'h0001) begin
      give_up("first line");
    end
    chk("line length", 16'h0280, line_len);
    // Even columns carry chroma zero, odd ones the clipped luma.
    for (int k = 0; k < 4; k++) begin
      chk("pixel code", k[0] ? 16'h00F0 : 16'h0080,
          {8'h00, i_swsf_capture.bytes[k]});
    end
    while (line_valid !== 1'b1 && gap < 200) begin
      @(negedge clock);
      if (rose_now()) begin
        gap++;
      end
    end
    chk("blank ticks", 16'h0018, 16'(gap));
    $display("test geometry hold done");
  endtask : test_geometry_hold

  // Starving the buffer mid-line shows black and raises underrun.
  task automatic test_underrun;
    sample_valid = 1'b0;
    for (int i = 0; i < 1000 && underrun !== 1'b1; i++) begin
      @(negedge clock);
    end
    if (underrun !== 1'b1) begin
      give_up("underrun");
    end
    chk("underrun byte", 16'h0110, {7'h00, line_valid, pix_data});
    chk("ready when empty", 16'h0001, {15'h0000, sample_ready});
    chk("reserved codes", 16'h0000, reserved_cnt);
    $display("test underrun done");
  endtask : test_underrun

  // Main sequence.
  initial begin
    reset_n = 1'b0;
    master_mode = 1'b1;
    data_edge_select = 1'b0;
    quarter_res = 1'b0;
    out_format = fmt_ycbcr;
    win_col_start = 10'h00C;
    win_row_start = 9'h006;
    win_cols = 10'h280;
    win_rows = 9'h1E0;
    luma_sample = 10'h3FF;
    chroma_sample = 10'h200;
    sample_valid = 1'b0;
    repeat (5) @(negedge clock);
    test_reset();
    reset_n = 1'b1;
    test_sync_rate();
    test_fifo_full();
    test_geometry_hold();
    test_underrun();
    end_sim();
  end

  // A hang anywhere ends the run as a failure.
  initial begin
    #4000000;
    give_up("watchdog");
  end
endmodule : swsf_formatter_test
